// file: imupm_pkg.sv
// Constants, field layout and types for the sensor power mode and rate controller
// How it works
// - Boot 20 ms, then both sensors power-down
// - Each sensor has its own independent mode
// - Shared phase counter keeps rates integer multiples
// - Gyro data ready follows accel data ready
// - Accel rate code and disable bit pick mode
// - Gyro decodes alike, codes up to 1000
// - Override forces gyro 3.3 kHz high-performance
// - Power-down keeps bus, registers, last sample
// - High-performance keeps chain on, data ready active
// - Normal mode cycles chain; gyro drive stays
// - Low-power only at the three lowest rates
// - Gyro sleep bit overrides rate, drive stays
// - Accel-only: rate change resets reading chain
// - Accel-only: mode change alone gives no reset
// - Gyro-only or combo: any change resets chain
// - Anti-alias filter only in high-performance
// - Bandwidth from field or from selected rate
package imupm_pkg;

	// Clock and timing
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int BOOT_TIME_MS = 20;
	localparam int BOOT_CYCLES = BOOT_TIME_MS * (CLK_HZ / 1000);
	localparam int BASE_PERIOD_NS = 150150;
	localparam int BASE_TICK_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int CHAIN_ON_CYCLES = 16;
	localparam int SAMPLE_WIDTH = 16;

	// Register byte offsets
	localparam logic [5:0] ADDR_ACCEL_CONTROL_ONE = 6'h00;
	localparam logic [5:0] ADDR_GYRO_CONTROL_TWO = 6'h04;
	localparam logic [5:0] ADDR_COMMON_CONTROL_FOUR = 6'h08;
	localparam logic [5:0] ADDR_COMMON_CONTROL_SIX = 6'h0C;
	localparam logic [5:0] ADDR_GYRO_CONTROL_SEVEN = 6'h10;
	localparam logic [5:0] ADDR_COMMON_CONTROL_TEN = 6'h14;
	localparam logic [5:0] ADDR_STATUS = 6'h18;
	localparam logic [5:0] ADDR_ACCEL_DATA = 6'h1C;
	localparam logic [5:0] ADDR_GYRO_DATA = 6'h20;

	// Reset value of every control register
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Field positions
	localparam int RATE_LSB = 4;
	localparam int ACCEL_BW_LSB = 0;
	localparam int GYRO_FS_LSB = 0;
	localparam int GYRO_OVERRIDE_BIT = 0;
	localparam int GYRO_SLEEP_BIT = 6;
	localparam int ACCEL_BW_SCALING_BIT = 7;
	localparam int ACCEL_PERF_DISABLE_BIT = 4;
	localparam int GYRO_PERF_DISABLE_BIT = 7;
	localparam int GYRO_HP_ENABLE_BIT = 6;
	localparam int EMBEDDED_ENABLE_BIT = 2;

	// Status register bit positions
	localparam int ST_BOOT_DONE = 0;
	localparam int ST_ACCEL_READY = 1;
	localparam int ST_GYRO_READY = 2;
	localparam int ST_GYRO_SLEEP = 3;
	localparam int ST_ACCEL_MODE_LSB = 4;
	localparam int ST_GYRO_MODE_LSB = 6;

	// Rate codes
	localparam logic [3:0] RATE_POWER_DOWN = 4'h0;
	localparam logic [3:0] LOW_POWER_RATE_MAX = 4'h3;
	localparam logic [3:0] NORMAL_RATE_MAX = 4'h5;
	localparam logic [3:0] ACCEL_RATE_MAX = 4'hA;
	localparam logic [3:0] GYRO_RATE_MAX = 4'h8;
	localparam logic [3:0] TOP_RATE_CODE = 4'hA;
	localparam logic [3:0] GYRO_OVERRIDE_EXP = 4'h1;
	localparam logic [3:0] RATE_104 = 4'h4;
	localparam logic [3:0] RATE_208 = 4'h5;
	localparam logic [3:0] RATE_416 = 4'h6;
	localparam logic [3:0] RATE_1K66 = 4'h8;

	// Anti-alias bandwidth codes
	localparam logic [1:0] BW_400 = 2'h0;
	localparam logic [1:0] BW_200 = 2'h1;
	localparam logic [1:0] BW_100 = 2'h2;
	localparam logic [1:0] BW_50 = 2'h3;

	// Power modes of one sensor
	typedef enum logic [1:0] {
		PWR_DOWN,
		PWR_LOW,
		PWR_NORMAL,
		PWR_HIGH
	} imupm_mode_type;

	// Boot sequencer states
	typedef enum logic {
		PH_BOOTING,
		PH_RUNNING
	} imupm_phase_type;

	// Decoded state of one sensor
	typedef struct packed {
		imupm_mode_type mode;
		logic [3:0] div_exp;
		logic active;
	} imupm_sensor_type;

endpackage

// file: imupm_mode_decode.sv
// Rate code and performance bit decoder for one sensor
`timescale 1ns/1ps
module imupm_mode_decode
	import imupm_pkg::*;
(
	input wire logic [3:0] rate_code, // Rate code from control register
	input wire logic perf_disable, // High-performance disable bit
	input wire logic [3:0] max_code, // Highest legal rate code
	input wire logic force_high, // Fixed high-rate override
	output imupm_sensor_type state // Decoded mode and divider
);

	// Decode mode and divider exponent
	always_comb begin
		state.mode = PWR_DOWN;
		state.div_exp = 4'h0;
		state.active = 1'b0;
		if (force_high) begin
			state.mode = PWR_HIGH;
			state.div_exp = GYRO_OVERRIDE_EXP;
			state.active = 1'b1;
		end else if (rate_code != RATE_POWER_DOWN && rate_code <= max_code) begin
			state.active = 1'b1;
			state.div_exp = TOP_RATE_CODE - rate_code;
			if (!perf_disable || rate_code > NORMAL_RATE_MAX) begin
				state.mode = PWR_HIGH;
			end else if (rate_code <= LOW_POWER_RATE_MAX) begin
				state.mode = PWR_LOW;
			end else begin
				state.mode = PWR_NORMAL;
			end
		end
		// Codes past max_code fall through as power-down
	end

endmodule

// file: imupm_core.sv
// Top of the sensor power mode and output rate controller with its register slave
`timescale 1ns/1ps
module imupm_core
	import imupm_pkg::*;
#(
	parameter int BOOT_LEN = BOOT_CYCLES, // Boot length in cycles
	parameter int TICK_LEN = BASE_TICK_CYCLES // Cycles per fastest sample tick
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [5:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	input wire logic [SAMPLE_WIDTH-1:0] accel_sample_in, // Accel converter result
	input wire logic [SAMPLE_WIDTH-1:0] gyro_sample_in, // Gyro converter result
	output logic accel_data_ready, // Accel new sample flag
	output logic gyro_data_ready, // Gyro new sample flag
	output logic accel_chain_on, // Accel reading chain power
	output logic gyro_chain_on, // Gyro reading chain power
	output logic gyro_drive_on, // Gyro mass drive power
	output logic accel_chain_reset, // Accel reading chain reset pulse
	output logic gyro_chain_reset, // Gyro reading chain reset pulse
	output logic accel_aa_enable, // Accel anti-alias filter on
	output logic [1:0] accel_aa_bw, // Accel anti-alias bandwidth code
	output logic embedded_function_enable, // Embedded function enable
	output logic [3:0] gyro_full_scale, // Gyro full-scale field
	output logic gyro_hp_enable // Gyro high-pass enable
);

	localparam int TICK_W = $clog2(TICK_LEN + 1);
	localparam int BOOT_W = $clog2(BOOT_LEN + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_LEN - 1);
	localparam logic [BOOT_W-1:0] BOOT_LAST = BOOT_W'(BOOT_LEN - 1);
	localparam logic [4:0] CHAIN_LOAD = 5'(CHAIN_ON_CYCLES);

	// Control registers
	logic [7:0] accel_control_one_q; // Accel rate and bandwidth
	logic [7:0] gyro_control_two_q; // Gyro rate and full scale
	logic [7:0] common_control_four_q; // Sleep, override, scaling
	logic [7:0] common_control_six_q; // Accel perf disable
	logic [7:0] gyro_control_seven_q; // Gyro perf disable, high-pass
	logic [7:0] common_control_ten_q; // Embedded functions

	// Boot and bus state
	imupm_phase_type phase_q; // Boot sequencer
	logic [BOOT_W-1:0] boot_cnt_q; // Boot timer
	logic wait_q; // Registered waitrequest
	logic [31:0] rdata_q; // Registered read data

	// Sampling state
	logic [TICK_W-1:0] tick_cnt_q; // Base tick divider
	logic base_tick; // Fastest rate tick
	logic [9:0] phase_cnt_q; // Shared sample phase
	logic accel_strobe; // Accel sample moment
	logic gyro_strobe; // Gyro sample moment
	logic gyro_strobe_q; // Gyro capture, one cycle late
	logic [SAMPLE_WIDTH-1:0] accel_s1_q, accel_s2_q; // Accel pin sync
	logic [SAMPLE_WIDTH-1:0] gyro_s1_q, gyro_s2_q; // Gyro pin sync
	logic [SAMPLE_WIDTH-1:0] accel_data_q, gyro_data_q; // Held samples
	logic accel_ready_q, gyro_ready_q; // Sticky data-ready flags
	logic [4:0] accel_win_q, gyro_win_q; // Chain on windows

	// Change detection
	logic [3:0] accel_rate_prev_q, gyro_rate_prev_q; // Last effective rates
	imupm_mode_type accel_mode_prev_q, gyro_mode_prev_q; // Last modes
	logic gyro_sleep; // Gyro in sleep

	// Output flops
	logic accel_chain_on_q, gyro_chain_on_q, gyro_drive_on_q; // Power outputs
	logic accel_reset_q, gyro_reset_q; // Reset pulses
	logic accel_aa_en_q; // Anti-alias enable
	logic [1:0] accel_aa_bw_q; // Anti-alias bandwidth

	// Decoded sensors
	imupm_sensor_type accel_st, gyro_st; // Decoder results
	logic [3:0] accel_rate_eff, gyro_rate_eff; // Rate with illegal codes zeroed
	logic bus_acc; // Bus request accepted this edge

	imupm_mode_decode u_accel_dec (
		.rate_code(accel_control_one_q[RATE_LSB +: 4]),
		.perf_disable(common_control_six_q[ACCEL_PERF_DISABLE_BIT]),
		.max_code(ACCEL_RATE_MAX),
		.force_high(1'b0),
		.state(accel_st)
	);

	imupm_mode_decode u_gyro_dec (
		.rate_code(gyro_control_two_q[RATE_LSB +: 4]),
		.perf_disable(gyro_control_seven_q[GYRO_PERF_DISABLE_BIT]),
		.max_code(GYRO_RATE_MAX),
		.force_high(common_control_four_q[GYRO_OVERRIDE_BIT]),
		.state(gyro_st)
	);

	// Effective rates; an illegal code counts as power-down
	assign accel_rate_eff = accel_st.active ? accel_control_one_q[RATE_LSB +: 4] : RATE_POWER_DOWN;
	assign gyro_rate_eff = common_control_four_q[GYRO_OVERRIDE_BIT] ? 4'hF
		: (gyro_st.active ? gyro_control_two_q[RATE_LSB +: 4] : RATE_POWER_DOWN);
	assign gyro_sleep = gyro_st.active && common_control_four_q[GYRO_SLEEP_BIT];
	assign bus_acc = !wait_q && (avs_read || avs_write);

	// Boot sequencer: registers stay at power-down reset values until done
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= PH_BOOTING;
			boot_cnt_q <= '0;
		end else begin
			case (phase_q)
				PH_BOOTING: begin
					if (boot_cnt_q == BOOT_LAST) begin
						phase_q <= PH_RUNNING;
					end else begin
						boot_cnt_q <= boot_cnt_q + 1'b1;
					end
				end
				PH_RUNNING: begin
					phase_q <= PH_RUNNING;
				end
				default: begin
					phase_q <= PH_BOOTING;
				end
			endcase
		end
	end

	// Bus handshake: one wait state, held off during boot
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 1'b1;
		end else if (wait_q && (avs_read || avs_write) && phase_q == PH_RUNNING) begin
			wait_q <= 1'b0; // Bus answers in every mode
		end else begin
			wait_q <= 1'b1;
		end
	end

	// Read data mux, loaded the cycle before the request is taken
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (wait_q && avs_read) begin
			case (avs_address)
				ADDR_ACCEL_CONTROL_ONE: rdata_q <= {24'h000000, accel_control_one_q};
				ADDR_GYRO_CONTROL_TWO: rdata_q <= {24'h000000, gyro_control_two_q};
				ADDR_COMMON_CONTROL_FOUR: rdata_q <= {24'h000000, common_control_four_q};
				ADDR_COMMON_CONTROL_SIX: rdata_q <= {24'h000000, common_control_six_q};
				ADDR_GYRO_CONTROL_SEVEN: rdata_q <= {24'h000000, gyro_control_seven_q};
				ADDR_COMMON_CONTROL_TEN: rdata_q <= {24'h000000, common_control_ten_q};
				ADDR_STATUS: begin
					rdata_q <= 32'h0000_0000;
					rdata_q[ST_BOOT_DONE] <= (phase_q == PH_RUNNING);
					rdata_q[ST_ACCEL_READY] <= accel_ready_q;
					rdata_q[ST_GYRO_READY] <= gyro_ready_q;
					rdata_q[ST_GYRO_SLEEP] <= gyro_sleep;
					rdata_q[ST_ACCEL_MODE_LSB +: 2] <= accel_st.mode;
					rdata_q[ST_GYRO_MODE_LSB +: 2] <= gyro_st.mode;
				end
				ADDR_ACCEL_DATA: rdata_q <= {16'h0000, accel_data_q};
				ADDR_GYRO_DATA: rdata_q <= {16'h0000, gyro_data_q};
				default: rdata_q <= 32'h0000_0000; // Unmapped reads zero
			endcase
		end
	end

	// Control register writes, lane 0 only; kept through power-down
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accel_control_one_q <= CTRL_RESET;
			gyro_control_two_q <= CTRL_RESET;
			common_control_four_q <= CTRL_RESET;
			common_control_six_q <= CTRL_RESET;
			gyro_control_seven_q <= CTRL_RESET;
			common_control_ten_q <= CTRL_RESET;
		end else if (bus_acc && avs_write && avs_byteenable[0]) begin
			case (avs_address)
				ADDR_ACCEL_CONTROL_ONE: accel_control_one_q <= avs_writedata[7:0];
				ADDR_GYRO_CONTROL_TWO: gyro_control_two_q <= avs_writedata[7:0];
				ADDR_COMMON_CONTROL_FOUR: common_control_four_q <= avs_writedata[7:0];
				ADDR_COMMON_CONTROL_SIX: common_control_six_q <= avs_writedata[7:0];
				ADDR_GYRO_CONTROL_SEVEN: gyro_control_seven_q <= avs_writedata[7:0];
				ADDR_COMMON_CONTROL_TEN: common_control_ten_q <= avs_writedata[7:0];
				default: begin
				end
			endcase
		end
	end

	// Base tick at the fastest rate; shared phase keeps rates locked
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= '0;
			phase_cnt_q <= 10'h000;
		end else if (tick_cnt_q == TICK_LAST) begin
			tick_cnt_q <= '0;
			phase_cnt_q <= phase_cnt_q + 10'h001;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	assign base_tick = (tick_cnt_q == TICK_LAST);
	// Each sensor samples when its low phase bits are zero
	assign accel_strobe = base_tick && accel_st.active && phase_cnt_q[9:0] == (phase_cnt_q[9:0]
		& ~((10'h001 << accel_st.div_exp) - 10'h001));
	assign gyro_strobe = base_tick && gyro_st.active && !gyro_sleep && phase_cnt_q[9:0] == (phase_cnt_q[9:0]
		& ~((10'h001 << gyro_st.div_exp) - 10'h001));

	// Two-flop synchronisers on the converter inputs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accel_s1_q <= '0;
			accel_s2_q <= '0;
			gyro_s1_q <= '0;
			gyro_s2_q <= '0;
		end else begin
			accel_s1_q <= accel_sample_in;
			accel_s2_q <= accel_s1_q;
			gyro_s1_q <= gyro_sample_in;
			gyro_s2_q <= gyro_s1_q;
		end
	end

	// Gyro capture trails accel by one cycle so its flag comes later
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gyro_strobe_q <= 1'b0;
		end else begin
			gyro_strobe_q <= gyro_strobe;
		end
	end

	// Accel sample hold; no update in power-down
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accel_data_q <= '0;
		end else if (accel_strobe) begin
			accel_data_q <= accel_s2_q;
		end
	end

	// Gyro sample hold; no update in power-down or sleep
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gyro_data_q <= '0;
		end else if (gyro_strobe_q) begin
			gyro_data_q <= gyro_s2_q;
		end
	end

	// Data-ready flags: set on capture, cleared by reading the data; set wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accel_ready_q <= 1'b0;
			gyro_ready_q <= 1'b0;
		end else begin
			if (accel_strobe) begin
				accel_ready_q <= 1'b1;
			end else if (bus_acc && avs_read && avs_address == ADDR_ACCEL_DATA) begin
				accel_ready_q <= 1'b0;
			end
			if (gyro_strobe_q) begin
				gyro_ready_q <= 1'b1;
			end else if (bus_acc && avs_read && avs_address == ADDR_GYRO_DATA) begin
				gyro_ready_q <= 1'b0;
			end
		end
	end

	// Duty-cycled chain windows for normal and low-power modes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accel_win_q <= 5'h00;
			gyro_win_q <= 5'h00;
		end else begin
			if (accel_strobe) begin
				accel_win_q <= CHAIN_LOAD;
			end else if (accel_win_q != 5'h00) begin
				accel_win_q <= accel_win_q - 5'h01;
			end
			if (gyro_strobe) begin
				gyro_win_q <= CHAIN_LOAD;
			end else if (gyro_win_q != 5'h00) begin
				gyro_win_q <= gyro_win_q - 5'h01;
			end
		end
	end

	// Chain and drive power outputs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accel_chain_on_q <= 1'b0;
			gyro_chain_on_q <= 1'b0;
			gyro_drive_on_q <= 1'b0;
		end else begin
			accel_chain_on_q <= (accel_st.mode == PWR_HIGH) ? 1'b1
				: (accel_st.active && (accel_win_q != 5'h00 || accel_strobe));
			gyro_chain_on_q <= !gyro_sleep && ((gyro_st.mode == PWR_HIGH)
				|| (gyro_st.active && (gyro_win_q != 5'h00 || gyro_strobe)));
			gyro_drive_on_q <= gyro_st.active;
		end
	end

	// Remember last effective rate and mode for change detection
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accel_rate_prev_q <= RATE_POWER_DOWN;
			gyro_rate_prev_q <= RATE_POWER_DOWN;
			accel_mode_prev_q <= PWR_DOWN;
			gyro_mode_prev_q <= PWR_DOWN;
		end else begin
			accel_rate_prev_q <= accel_rate_eff;
			gyro_rate_prev_q <= gyro_rate_eff;
			accel_mode_prev_q <= accel_st.mode;
			gyro_mode_prev_q <= gyro_st.mode;
		end
	end

	// Reading chain reset pulses on configuration changes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accel_reset_q <= 1'b0;
			gyro_reset_q <= 1'b0;
		end else begin
			if (!gyro_st.active) begin
				accel_reset_q <= (accel_rate_eff != accel_rate_prev_q);
			end else begin
				accel_reset_q <= (accel_rate_eff != accel_rate_prev_q)
					|| (accel_st.mode != accel_mode_prev_q);
			end
			gyro_reset_q <= (gyro_rate_eff != gyro_rate_prev_q)
				|| (gyro_st.mode != gyro_mode_prev_q);
		end
	end

	// Anti-alias filter enable and bandwidth
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			accel_aa_en_q <= 1'b0;
			accel_aa_bw_q <= BW_400;
		end else if (common_control_four_q[ACCEL_BW_SCALING_BIT]) begin
			accel_aa_en_q <= (accel_st.mode == PWR_HIGH);
			accel_aa_bw_q <= accel_control_one_q[ACCEL_BW_LSB +: 2];
		end else begin
			accel_aa_en_q <= (accel_st.mode == PWR_HIGH) && accel_rate_eff <= RATE_1K66;
			if (accel_rate_eff <= RATE_104) begin
				accel_aa_bw_q <= BW_50;
			end else if (accel_rate_eff == RATE_208) begin
				accel_aa_bw_q <= BW_100;
			end else if (accel_rate_eff == RATE_416) begin
				accel_aa_bw_q <= BW_200;
			end else begin
				accel_aa_bw_q <= BW_400;
			end
		end
	end

	// Pass-through settings, registered for glitch-free outputs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			embedded_function_enable <= 1'b0;
			gyro_full_scale <= 4'h0;
			gyro_hp_enable <= 1'b0;
		end else begin
			embedded_function_enable <= common_control_ten_q[EMBEDDED_ENABLE_BIT];
			gyro_full_scale <= gyro_control_two_q[GYRO_FS_LSB +: 4];
			gyro_hp_enable <= gyro_control_seven_q[GYRO_HP_ENABLE_BIT];
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign accel_data_ready = accel_ready_q;
	assign gyro_data_ready = gyro_ready_q;
	assign accel_chain_on = accel_chain_on_q;
	assign gyro_chain_on = gyro_chain_on_q;
	assign gyro_drive_on = gyro_drive_on_q;
	assign accel_chain_reset = accel_reset_q;
	assign gyro_chain_reset = gyro_reset_q;
	assign accel_aa_enable = accel_aa_en_q;
	assign accel_aa_bw = accel_aa_bw_q;

endmodule

// file: imupm_asserts.sv
// Port-level checks for the power mode and rate controller
`timescale 1ns/1ps
module imupm_checker
	import imupm_pkg::*;
#(
	parameter int BOOT_LEN = BOOT_CYCLES // Boot length in cycles
) (
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic avs_read, // Read strobe
	input wire logic avs_write, // Write strobe
	input wire logic avs_waitrequest, // Stall
	input wire logic accel_data_ready, // Accel flag
	input wire logic gyro_data_ready, // Gyro flag
	input wire logic accel_chain_on, // Accel chain power
	input wire logic gyro_chain_on, // Gyro chain power
	input wire logic gyro_drive_on, // Gyro drive power
	input wire logic accel_chain_reset, // Accel chain reset
	input wire logic accel_aa_enable // Anti-alias on
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	int unsigned run_q; // Cycles since reset release
	int unsigned wr_q; // Cycles since the last taken write
	// Saturating count of cycles since reset release
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 0;
		end else if (run_q < BOOT_LEN) begin
			run_q <= run_q + 1;
		end
	end
	// Age of the last taken write, saturating at 100
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= 100;
		end else if (avs_write && !avs_waitrequest) begin
			wr_q <= 0;
		end else if (wr_q < 100) begin
			wr_q <= wr_q + 1;
		end
	end
	// A bus request taken at this edge
	sequence s_taken;
		(avs_read || avs_write) && !avs_waitrequest;
	endsequence
	// Accel chain unpowered for four cycles
	sequence s_chain_idle;
		!accel_chain_on [*4];
	endsequence
	AST_BOOT_STALL: assert property (run_q < BOOT_LEN |-> avs_waitrequest)
		else $error("request answered during boot");
	AST_WAIT_ONE: assert property (s_taken |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_WAIT_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("answer without request");
	AST_DRDY_ORDER: assert property ($rose(gyro_data_ready) |-> !$rose(accel_data_ready))
		else $error("gyro ready together with accel ready");
	AST_ACCEL_CHAIN: assert property ($rose(accel_data_ready) |-> accel_chain_on)
		else $error("accel sample while chain off");
	AST_GYRO_CHAIN: assert property ($rose(gyro_data_ready) |-> gyro_chain_on)
		else $error("gyro sample while chain off");
	AST_GYRO_DRIVE: assert property (gyro_chain_on |-> gyro_drive_on)
		else $error("gyro chain on without drive");
	AST_RESET_PULSE: assert property (accel_chain_reset |=> !accel_chain_reset)
		else $error("chain reset longer than one cycle");
	AST_RESET_CAUSE: assert property (accel_chain_reset |-> wr_q <= 4)
		else $error("chain reset without a write");
	AST_AA_HP: assert property (s_chain_idle |-> !accel_aa_enable)
		else $error("anti-alias on outside high performance");
endmodule

bind imupm_core imupm_checker #(.BOOT_LEN(BOOT_LEN)) u_chk (.clk_sys, .rst_n, .avs_read, .avs_write,
	.avs_waitrequest, .accel_data_ready, .gyro_data_ready, .accel_chain_on, .gyro_chain_on,
	.gyro_drive_on, .accel_chain_reset, .accel_aa_enable);

// file: imupm_sensor_model.sv
// Converter model feeding samples to the controller
`timescale 1ns/1ps
module imupm_sensor_model
	import imupm_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic accel_chain_on, // Accel chain power
	input wire logic gyro_chain_on, // Gyro chain power
	output logic [SAMPLE_WIDTH-1:0] accel_sample_in, // Accel result
	output logic [SAMPLE_WIDTH-1:0] gyro_sample_in // Gyro result
);
	// Fresh value while powered, toggling junk while off
	initial begin
		accel_sample_in = 16'h1000;
		gyro_sample_in = 16'h2000;
	end
	always @(posedge clk_sys) begin
		accel_sample_in <= accel_chain_on ? accel_sample_in + 16'h0001 : ~accel_sample_in;
		gyro_sample_in <= gyro_chain_on ? gyro_sample_in + 16'h0003 : ~gyro_sample_in;
	end
endmodule

// file: tb_imu_power_mode_rate_control.sv
// Self-checking bench for the power mode and rate controller
`timescale 1ns/1ps
module tb_imu_power_mode_rate_control
	import imupm_pkg::*;
;
	localparam int BL = 20; // Short boot
	logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest; // Clock, reset, bus
	logic [5:0] avs_address; // Bus address
	logic [31:0] avs_writedata, avs_readdata, v; // Bus data, last read
	logic [3:0] avs_byteenable, gyro_full_scale; // Lanes, full scale
	logic [15:0] accel_sample_in, gyro_sample_in; // Samples
	logic accel_data_ready, gyro_data_ready, accel_chain_on, gyro_chain_on, gyro_drive_on; // Outputs
	logic accel_chain_reset, gyro_chain_reset, accel_aa_enable, embedded_function_enable, gyro_hp_enable;
	logic [1:0] accel_aa_bw; // Bandwidth code
	int n_mismatch, checks_done, n_arst, cyc; // Counters
	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	imupm_core #(.BOOT_LEN(BL), .TICK_LEN(8)) uut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .accel_sample_in, .gyro_sample_in,
		.accel_data_ready, .gyro_data_ready, .accel_chain_on, .gyro_chain_on, .gyro_drive_on, .accel_chain_reset,
		.gyro_chain_reset, .accel_aa_enable, .accel_aa_bw, .embedded_function_enable, .gyro_full_scale,
		.gyro_hp_enable);
	imupm_sensor_model u_model (.clk_sys, .accel_chain_on, .gyro_chain_on, .accel_sample_in, .gyro_sample_in);
	// Cycle count; each accel reset pulse adds one, each gyro reset pulse sixteen
	always @(posedge clk_sys) begin
		cyc++;
		n_arst += int'(accel_chain_reset === 1'b1) + 16 * int'(gyro_chain_reset === 1'b1);
	end
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One bus transfer held until waitrequest is low
	task automatic bus(logic w, logic [5:0] a, logic [7:0] d, logic [3:0] b);
		avs_read <= ~w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= b;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		v = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr8(logic [5:0] a, logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rd8(logic [5:0] a);
		bus(1'b0, a, 8'h00, 4'hF);
	endtask
	task automatic waitn(int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// Expected power mode from code, disable bit and top code
	function automatic logic [1:0] emode(logic [3:0] c, logic p, logic [3:0] mx);
		if (c == 4'h0 || c > mx) return 2'h0;
		if (c > 4'h5 || !p) return 2'h3;
		return (c > 4'h3) ? 2'h2 : 2'h1;
	endfunction
	task automatic t_boot;
		int t0;
		t0 = cyc;
		rd8(ADDR_STATUS);
		chk("boot wait", 32'h1, {31'h0, (cyc - t0) > BL});
		chk("boot status", 32'h1, v);
		bus(1'b1, ADDR_GYRO_CONTROL_SEVEN, 8'hC0, 4'h0);
		rd8(ADDR_GYRO_CONTROL_SEVEN);
		chk("masked write", CTRL_RESET, v);
		rd8(6'h3C);
		chk("unmapped", 32'h0, v);
	endtask
	task automatic t_sensor(logic g);
		wr8(ADDR_COMMON_CONTROL_TEN, 8'h04);
		for (int p = 0; p < 2; p++) begin
			wr8(g ? ADDR_GYRO_CONTROL_SEVEN : ADDR_COMMON_CONTROL_SIX, p[0] ? (g ? 8'h80 : 8'h10) : 8'h00);
			for (int c = 0; c < 16; c++) begin
				wr8(g ? ADDR_GYRO_CONTROL_TWO : ADDR_ACCEL_CONTROL_ONE, {c[3:0], 4'h0});
				rd8(ADDR_STATUS);
				chk("mode", emode(c[3:0], p[0], g ? 4'h8 : 4'hA), g ? v[7:6] : v[5:4]);
			end
		end
		chk("embedded enable", 32'h1, embedded_function_enable);
	endtask
	task automatic t_gyro_extra;
		wr8(ADDR_GYRO_CONTROL_SEVEN, 8'h40);
		wr8(ADDR_GYRO_CONTROL_TWO, 8'h25);
		wr8(ADDR_COMMON_CONTROL_FOUR, 8'h01);
		rd8(ADDR_STATUS);
		chk("override", 32'h35, {v[7:6], gyro_full_scale});
		chk("hp enable", 32'h1, gyro_hp_enable);
		wr8(ADDR_COMMON_CONTROL_FOUR, 8'h40);
		rd8(ADDR_STATUS);
		chk("sleep", 32'h5, {v[3], gyro_chain_on, gyro_drive_on});
	endtask
	task automatic t_chain;
		wr8(ADDR_GYRO_CONTROL_TWO, 8'h00);
		wr8(ADDR_COMMON_CONTROL_FOUR, 8'h00);
		wr8(ADDR_COMMON_CONTROL_SIX, 8'h00);
		wr8(ADDR_ACCEL_CONTROL_ONE, 8'h40);
		waitn(4);
		n_arst = 0;
		wr8(ADDR_COMMON_CONTROL_SIX, 8'h10);
		waitn(4);
		chk("mode only", 32'h0, n_arst);
		wr8(ADDR_ACCEL_CONTROL_ONE, 8'h00);
		wr8(ADDR_ACCEL_CONTROL_ONE, 8'h40);
		wr8(ADDR_COMMON_CONTROL_SIX, 8'h00);
		wr8(ADDR_ACCEL_CONTROL_ONE, 8'h50);
		waitn(4);
		chk("rate resets", 32'h3, n_arst);
		n_arst = 0;
		wr8(ADDR_GYRO_CONTROL_TWO, 8'h50);
		waitn(4);
		wr8(ADDR_COMMON_CONTROL_SIX, 8'h10);
		waitn(4);
		chk("combo reset", 32'h11, n_arst);
	endtask
	task automatic t_data;
		logic a_at;
		logic [31:0] x;
		a_at = 1'b0;
		wr8(ADDR_COMMON_CONTROL_SIX, 8'h00);
		rd8(ADDR_ACCEL_DATA);
		rd8(ADDR_GYRO_DATA);
		for (int i = 0; i < 3000 && gyro_data_ready !== 1'b1; i++) begin
			a_at = accel_data_ready;
			@(posedge clk_sys);
		end
		chk("accel first", 32'h1, a_at);
		wr8(ADDR_ACCEL_CONTROL_ONE, 8'h00);
		rd8(ADDR_ACCEL_DATA);
		x = v;
		waitn(600);
		chk("gyro chain", 32'h1, gyro_chain_on);
		chk("no new data", 32'h0, accel_data_ready);
		rd8(ADDR_ACCEL_DATA);
		chk("held sample", x, v);
	endtask
	task automatic t_aa;
		wr8(ADDR_COMMON_CONTROL_FOUR, 8'h80);
		for (int b = 0; b < 4; b++) begin
			wr8(ADDR_ACCEL_CONTROL_ONE, {6'h18, b[1:0]});
			waitn(3);
			chk("aa field", {29'h0, 1'b1, b[1:0]}, {29'h0, accel_aa_enable, accel_aa_bw});
		end
		wr8(ADDR_COMMON_CONTROL_FOUR, 8'h00);
		waitn(3);
		chk("aa by rate", 32'h5, {accel_aa_enable, accel_aa_bw});
		wr8(ADDR_COMMON_CONTROL_SIX, 8'h10);
		wr8(ADDR_ACCEL_CONTROL_ONE, 8'h40);
		waitn(3);
		chk("aa normal", 32'h0, accel_aa_enable);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#2000000;
		n_mismatch++;
		tally_and_finish;
	end
	// Main sequence
	initial begin
		{rst_n, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
		{n_mismatch, checks_done, n_arst, cyc} = '0;
		waitn(20);
		rst_n <= 1'b1;
		t_boot;
		t_sensor(1'b0);
		t_sensor(1'b1);
		t_gyro_extra;
		t_chain;
		t_data;
		t_aa;
		tally_and_finish;
	end
endmodule
